// file: hdl/acf_classifier.v
/*
 * Access-control frame classifier: a table of entries matched against
 * frame headers from the ingress datapath, with per-entry actions and hit
 * counters, configured over AXI4-Lite.
 * Assumes frame header fields come from logic on clk, one frame per
 * frmValid pulse, and that the forwarding pipeline takes the registered
 * result one cycle later.
 */
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.

// How it works
// RULE_01 - Ethernet-type class matches only length/type at least 0x0600.
// RULE_02 - ARP class matches only ARP; ARP never hits Ethernet-type class.
// RULE_03 - IPv4 class matches only IPv4; never hits Ethernet-type class.
// RULE_04 - IPv6 class matches only IPv6; never hits Ethernet-type class.
// RULE_05 - A deny entry drops the frame.
// RULE_06 - A permit entry forwards the frame with its other operations.
// RULE_07 - An entry selects no rate limiter or one of sixteen.
// RULE_08 - Policer off by default; never enabled together with rate limiter.
// RULE_09 - An enabled policer references one identifier from 1 to 256.
// RULE_10 - Redirect to an in-range port; disabled leaves forwarding alone.
// RULE_11 - Mirroring copies matched frames; disabled after reset.
// RULE_12 - Logging reports matched frames shorter than 1518 bytes only.
// RULE_13 - Shutdown disables the port the matching frame arrived on.
// RULE_14 - Shutdown acts only for frames shorter than 1518 bytes.
// RULE_15 - Each entry counts every frame that matches it; the code counts only for the first matching entry, while enabled.
// RULE_16 - Source address criterion applies only to Ethernet-type or ARP.
// RULE_17 - Source don't-care matches all; specific needs equal address.
// RULE_18 - Destination don't-care, multicast, broadcast or unicast category.
// RULE_19 - Specific destination matches only the exact 48-bit address.
// RULE_20 - Entry applies to any ingress port or one selected port.
// RULE_21 - Specific policy compares 8-bit policy number under 8-bit mask.
// RULE_22 - First matching entry in list order decides the actions.
// RULE_23 - Unmatched frames forward normally, no action, no counter.
`include "acf_regs.vh"

module acf_classifier #(
    parameter NUM_ENT = 8,
    parameter PORT_W = 5,
    parameter NUM_PORTS = 28
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire frmValid,
    input wire [PORT_W-1:0] frmPort,
    input wire [7:0] frmPolicy,
    input wire [15:0] frmEtype,
    input wire [47:0] frmDa,
    input wire [47:0] frmSa,
    input wire [15:0] frmLen,
    output reg resValid,
    output reg resHit,
    output reg [2:0] resEntry,
    output reg resDrop,
    output reg resRateEn,
    output reg [3:0] resRateId,
    output reg resSpolEn,
    output reg [7:0] resSpolId,
    output reg resRedirEn,
    output reg [PORT_W-1:0] resRedirPort,
    output reg resMirror,
    output reg resLog,
    output reg resShutdown,
    output reg [PORT_W-1:0] resShutPort
);

    reg [31:0] ctrl_q;
    reg [31:0] frames_q;
    reg [31:0] status_q;
    reg [11:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    wire [NUM_ENT-1:0] matchVec;
    wire [NUM_ENT*32-1:0] ctrlFlat;
    wire [NUM_ENT*32-1:0] actFlat;
    wire [NUM_ENT*32-1:0] rdFlat;
    wire [NUM_ENT*32-1:0] cntFlat;
    reg wrFire;
    reg wrEntHit;
    reg wrGlobal;
    reg [2:0] wrEnt;
    reg rdEntHit;
    reg [2:0] rdEnt;
    reg [31:0] rdWord;
    reg rdOk;
    reg hit;
    reg [2:0] hitIdx;
    reg [31:0] hitCtrl;
    reg [31:0] hitAct;
    reg shortFrm;
    integer k;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are taken in either order.
    always @*
    begin
        wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
        wrEnt = awAddr_q[7:5];
        wrEntHit = (awAddr_q[11:8] == `ACF_ENT_PAGE) &&
            ({29'h00000000, wrEnt} < NUM_ENT);
        wrGlobal = (awAddr_q == `ACF_OFF_CTRL);
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACF_RESP_OK;
            awAddr_q <= 12'h000;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            ctrl_q <= `ACF_CTRL_RST;
        end
        else if (ce)
        begin
            ctrl_q[`ACF_CTRL_CLRALL] <= 1'b0;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wrEntHit || wrGlobal) ?
                    `ACF_RESP_OK : `ACF_RESP_ERR;
                if (wrGlobal && wStrb_q[0])
                begin
                    ctrl_q <= {30'h00000000, wData_q[1:0]};
                end
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: one cycle from address to data.
    always @*
    begin
        rdEnt = s_axi_araddr[7:5];
        rdEntHit = (s_axi_araddr[11:8] == `ACF_ENT_PAGE) &&
            ({29'h00000000, rdEnt} < NUM_ENT);
        rdOk = 1'b1;
        rdWord = 32'h00000000;
        if (rdEntHit)
        begin
            if (s_axi_araddr[4:2] == `ACF_EOFF_CNT)
            begin
                rdWord = cntFlat[rdEnt*32 +: 32];
            end
            else
            begin
                rdWord = rdFlat[rdEnt*32 +: 32];
            end
        end
        else if (s_axi_araddr == `ACF_OFF_CTRL)
        begin
            rdWord = ctrl_q;
        end
        else if (s_axi_araddr == `ACF_OFF_STATUS)
        begin
            rdWord = status_q;
        end
        else if (s_axi_araddr == `ACF_OFF_FRAMES)
        begin
            rdWord = frames_q;
        end
        else
        begin
            rdOk = 1'b0;
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ACF_RESP_OK;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdWord;
                s_axi_rresp <= rdOk ? `ACF_RESP_OK : `ACF_RESP_ERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Entry table with one hit counter per entry.
    genvar g;
    generate
        for (g = 0; g < NUM_ENT; g = g + 1)
        begin : gEnt
            wire cntClr;
            assign cntClr = ctrl_q[`ACF_CTRL_CLRALL] ||
                (wrFire && wrEntHit && wrEnt == g &&
                awAddr_q[4:2] == `ACF_EOFF_CNT);
            acf_entry #(
                .PORT_W(PORT_W)
            ) uEntry (
                .clk(clk),
                .arst_n(arst_n),
                .ce(ce),
                .wrEn(wrFire && wrEntHit && wrEnt == g),
                .wrOff(awAddr_q[4:2]),
                .wrData(wData_q),
                .rdOff(s_axi_araddr[4:2]),
                .rdData(rdFlat[g*32 +: 32]),
                .frmPort(frmPort),
                .frmPolicy(frmPolicy),
                .frmEtype(frmEtype),
                .frmDa(frmDa),
                .frmSa(frmSa),
                .cfgCtrl(ctrlFlat[g*32 +: 32]),
                .cfgAct(actFlat[g*32 +: 32]),
                .match(matchVec[g])
            );
            acf_counter #(
                .W(32)
            ) uCount (
                .clk(clk),
                .arst_n(arst_n),
                .ce(ce),
                .inc(frmValid && ctrl_q[`ACF_CTRL_EN] && hit &&
                    hitIdx == g), // RULE_15
                .clr(cntClr),
                .count(cntFlat[g*32 +: 32])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Lowest-numbered matching entry wins.
    always @*
    begin
        hit = 1'b0;
        hitIdx = 3'h0;
        for (k = NUM_ENT - 1; k >= 0; k = k - 1)
        begin
            if (matchVec[k])
            begin
                hit = 1'b1; // RULE_22
                hitIdx = k[2:0]; // RULE_22
            end
        end
        hitCtrl = ctrlFlat[hitIdx*32 +: 32];
        hitAct = actFlat[hitIdx*32 +: 32];
        shortFrm = frmLen < `ACF_LEN_LIMIT;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered verdict toward the forwarding pipeline.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            resValid <= 1'b0;
            resHit <= 1'b0;
            resEntry <= 3'h0;
            resDrop <= 1'b0;
            resRateEn <= 1'b0;
            resRateId <= 4'h0;
            resSpolEn <= 1'b0;
            resSpolId <= 8'h00;
            resRedirEn <= 1'b0;
            resRedirPort <= {PORT_W{1'b0}};
            resMirror <= 1'b0;
            resLog <= 1'b0;
            resShutdown <= 1'b0;
            resShutPort <= {PORT_W{1'b0}};
            frames_q <= 32'h00000000;
            status_q <= 32'h00000000;
        end
        else if (ce)
        begin
            resValid <= frmValid;
            if (frmValid)
            begin
                frames_q <= frames_q + 32'h00000001;
                resHit <= 1'b0; // RULE_23
                resEntry <= 3'h0;
                resDrop <= 1'b0;
                resRateEn <= 1'b0;
                resRateId <= 4'h0;
                resSpolEn <= 1'b0;
                resSpolId <= 8'h00;
                resRedirEn <= 1'b0;
                resRedirPort <= {PORT_W{1'b0}};
                resMirror <= 1'b0;
                resLog <= 1'b0;
                resShutdown <= 1'b0;
                resShutPort <= frmPort;
                if (ctrl_q[`ACF_CTRL_EN] && hit)
                begin
                    status_q <= {28'h0000000, 1'b1, hitIdx};
                    resHit <= 1'b1;
                    resEntry <= hitIdx;
                    resDrop <= hitCtrl[`ACF_F_DENY]; // RULE_05
                    if (!hitCtrl[`ACF_F_DENY]) // RULE_06
                    begin
                        resRateEn <= hitAct[`ACF_A_RATEEN]; // RULE_07
                        resRateId <= hitAct[`ACF_A_RATEID_HI:
                            `ACF_A_RATEID_LO]; // RULE_07
                        resSpolEn <= hitAct[`ACF_A_SPOLEN] &&
                            !hitAct[`ACF_A_RATEEN]; // RULE_08
                        resSpolId <= hitAct[`ACF_A_SPOLID_HI:
                            `ACF_A_SPOLID_LO]; // RULE_09
                        resRedirEn <= hitAct[`ACF_A_REDIREN] &&
                            ({{(32-PORT_W){1'b0}},
                            hitAct[`ACF_A_REDIR_LO+PORT_W-1:
                            `ACF_A_REDIR_LO]} < NUM_PORTS); // RULE_10
                        resRedirPort <= hitAct[`ACF_A_REDIR_LO+PORT_W-1:
                            `ACF_A_REDIR_LO]; // RULE_10
                        resMirror <= hitCtrl[`ACF_F_MIRROR]; // RULE_11
                    end
                    resLog <= hitCtrl[`ACF_F_LOG] && shortFrm; // RULE_12
                    resShutdown <= hitCtrl[`ACF_F_SHUT] &&
                        shortFrm; // RULE_14
                    resShutPort <= frmPort; // RULE_13
                end
            end
        end
    end

endmodule // acf_classifier

// file: inc/acf_regs.vh
/*
 * Register map, field positions, reset values and frame constants of the
 * access-control frame classifier.
 * Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
 */
`ifndef ACF_REGS_VH
`define ACF_REGS_VH

////////////////////////////////////////////////////////////////////////////
// Global registers.
`define ACF_OFF_CTRL 12'h000
`define ACF_OFF_STATUS 12'h004
`define ACF_OFF_FRAMES 12'h008
`define ACF_CTRL_EN 0
`define ACF_CTRL_CLRALL 1
`define ACF_CTRL_RST 32'h00000001

////////////////////////////////////////////////////////////////////////////
// Entry windows: base plus entry index times stride, word offsets below.
`define ACF_ENT_PAGE 4'h1
`define ACF_EOFF_CTRL 3'h0
`define ACF_EOFF_ACT 3'h1
`define ACF_EOFF_POL 3'h2
`define ACF_EOFF_SALO 3'h3
`define ACF_EOFF_SAHI 3'h4
`define ACF_EOFF_DALO 3'h5
`define ACF_EOFF_DAHI 3'h6
`define ACF_EOFF_CNT 3'h7

////////////////////////////////////////////////////////////////////////////
// Entry control word fields.
`define ACF_F_VALID 0
`define ACF_F_CLASS_LO 1
`define ACF_F_CLASS_HI 3
`define ACF_F_DENY 4
`define ACF_F_MIRROR 5
`define ACF_F_LOG 6
`define ACF_F_SHUT 7
`define ACF_F_PORTSPEC 8
`define ACF_F_PORT_LO 9
`define ACF_F_SMACSPEC 14
`define ACF_F_DMODE_LO 15
`define ACF_F_DMODE_HI 17
`define ACF_F_POLSPEC 18

// Entry action word fields.
`define ACF_A_RATEEN 0
`define ACF_A_RATEID_LO 1
`define ACF_A_RATEID_HI 4
`define ACF_A_SPOLEN 5
`define ACF_A_SPOLID_LO 6
`define ACF_A_SPOLID_HI 13
`define ACF_A_REDIREN 14
`define ACF_A_REDIR_LO 15

////////////////////////////////////////////////////////////////////////////
// Frame classes and destination address modes.
`define ACF_CLS_ANY 3'h0
`define ACF_CLS_ETYPE 3'h1
`define ACF_CLS_ARP 3'h2
`define ACF_CLS_IPV4 3'h3
`define ACF_CLS_IPV6 3'h4
`define ACF_DM_ANY 3'h0
`define ACF_DM_MC 3'h1
`define ACF_DM_BC 3'h2
`define ACF_DM_UC 3'h3
`define ACF_DM_SPEC 3'h4

`define ACF_ETYPE_MIN 16'h0600
`define ACF_ETYPE_ARP 16'h0806
`define ACF_ETYPE_RARP 16'h8035
`define ACF_ETYPE_IPV4 16'h0800
`define ACF_ETYPE_IPV6 16'h86DD
`define ACF_LEN_LIMIT 16'h05EE
`define ACF_RESP_OK 2'h0
`define ACF_RESP_ERR 2'h2

`endif

// file: hdl/acf_counter.v
/*
 * Hit counter of one entry with software clear.
 * Assumes inc and clr are single-cycle strobes on clk.
 */
module acf_counter #(
    parameter W = 32
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire inc,
    input wire clr,
    output reg [W-1:0] count
);

    // An increment in the clearing cycle survives the clear.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= {W{1'b0}};
        end
        else if (ce)
        begin
            if (clr)
            begin
                count <= {{(W-1){1'b0}}, inc};
            end
            else if (inc)
            begin
                count <= count + {{(W-1){1'b0}}, 1'b1}; // RULE_15
            end
        end
    end

endmodule // acf_counter

// file: hdl/acf_entry.v
/*
 * Configuration and match logic of one access control entry.
 * Assumes frame fields are stable on clk while frmValid is high.
 */
`include "acf_regs.vh"

module acf_entry #(
    parameter PORT_W = 5
) (
    input wire clk,
    input wire arst_n,
    input wire ce,
    input wire wrEn,
    input wire [2:0] wrOff,
    input wire [31:0] wrData,
    input wire [2:0] rdOff,
    output reg [31:0] rdData,
    input wire [PORT_W-1:0] frmPort,
    input wire [7:0] frmPolicy,
    input wire [15:0] frmEtype,
    input wire [47:0] frmDa,
    input wire [47:0] frmSa,
    output wire [31:0] cfgCtrl,
    output wire [31:0] cfgAct,
    output reg match
);

    reg [31:0] ctrl_q;
    reg [31:0] act_q;
    reg [15:0] pol_q;
    reg [31:0] saLo_q;
    reg [15:0] saHi_q;
    reg [31:0] daLo_q;
    reg [15:0] daHi_q;
    reg [31:0] actWr;
    reg isArp;
    reg isV4;
    reg isV6;
    reg isEth;
    reg clsOk;
    reg saOk;
    reg daOk;
    reg portOk;
    reg polOk;
    reg daBc;
    reg daMc;
    reg [2:0] cls;

    assign cfgCtrl = ctrl_q;
    assign cfgAct = act_q;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers; the policer is off after reset.
    always @*
    begin
        actWr = wrData;
        if (wrData[`ACF_A_RATEEN])
        begin
            actWr[`ACF_A_SPOLEN] = 1'b0; // RULE_08
        end
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl_q <= 32'h00000000;
            act_q <= 32'h00000000; // RULE_08
            pol_q <= 16'h0000;
            saLo_q <= 32'h00000000;
            saHi_q <= 16'h0000;
            daLo_q <= 32'h00000000;
            daHi_q <= 16'h0000;
        end
        else if (ce && wrEn)
        begin
            case (wrOff)
                `ACF_EOFF_CTRL: ctrl_q <= wrData;
                `ACF_EOFF_ACT: act_q <= actWr;
                `ACF_EOFF_POL: pol_q <= wrData[15:0];
                `ACF_EOFF_SALO: saLo_q <= wrData;
                `ACF_EOFF_SAHI: saHi_q <= wrData[15:0];
                `ACF_EOFF_DALO: daLo_q <= wrData;
                `ACF_EOFF_DAHI: daHi_q <= wrData[15:0];
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    always @*
    begin
        case (rdOff)
            `ACF_EOFF_CTRL: rdData = ctrl_q;
            `ACF_EOFF_ACT: rdData = act_q;
            `ACF_EOFF_POL: rdData = {16'h0000, pol_q};
            `ACF_EOFF_SALO: rdData = saLo_q;
            `ACF_EOFF_SAHI: rdData = {16'h0000, saHi_q};
            `ACF_EOFF_DALO: rdData = daLo_q;
            `ACF_EOFF_DAHI: rdData = {16'h0000, daHi_q};
            default: rdData = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Match criteria.
    always @*
    begin
        cls = ctrl_q[`ACF_F_CLASS_HI:`ACF_F_CLASS_LO];
        isArp = (frmEtype == `ACF_ETYPE_ARP) ||
            (frmEtype == `ACF_ETYPE_RARP);
        isV4 = frmEtype == `ACF_ETYPE_IPV4;
        isV6 = frmEtype == `ACF_ETYPE_IPV6;
        isEth = (frmEtype >= `ACF_ETYPE_MIN) && !isArp && !isV4 && !isV6;
        case (cls)
            `ACF_CLS_ANY: clsOk = 1'b1;
            `ACF_CLS_ETYPE: clsOk = isEth; // RULE_01
            `ACF_CLS_ARP: clsOk = isArp; // RULE_02
            `ACF_CLS_IPV4: clsOk = isV4; // RULE_03
            `ACF_CLS_IPV6: clsOk = isV6; // RULE_04
            default: clsOk = 1'b0;
        endcase
        saOk = 1'b1;
        if ((cls == `ACF_CLS_ETYPE || cls == `ACF_CLS_ARP) && // RULE_16
            ctrl_q[`ACF_F_SMACSPEC])
        begin
            saOk = frmSa == {saHi_q, saLo_q}; // RULE_17
        end
        daBc = &frmDa;
        daMc = frmDa[40] && !daBc;
        case (ctrl_q[`ACF_F_DMODE_HI:`ACF_F_DMODE_LO])
            `ACF_DM_ANY: daOk = 1'b1; // RULE_18
            `ACF_DM_MC: daOk = daMc; // RULE_18
            `ACF_DM_BC: daOk = daBc; // RULE_18
            `ACF_DM_UC: daOk = !frmDa[40]; // RULE_18
            `ACF_DM_SPEC: daOk = frmDa == {daHi_q, daLo_q}; // RULE_19
            default: daOk = 1'b0;
        endcase
        portOk = !ctrl_q[`ACF_F_PORTSPEC] || // RULE_20
            (frmPort == ctrl_q[`ACF_F_PORT_LO+PORT_W-1:`ACF_F_PORT_LO]);
        polOk = !ctrl_q[`ACF_F_POLSPEC] ||
            (((frmPolicy ^ pol_q[7:0]) & pol_q[15:8]) == 8'h00); // RULE_21
        match = ctrl_q[`ACF_F_VALID] && clsOk && saOk && daOk &&
            portOk && polOk;
    end

endmodule // acf_entry

// file: bench/acf_classifier_props.sv
/*
 * Checker of the classifier verdict seen at the top-level ports.
 * Assumes one clock domain, ce held high and arst_n asynchronous.
 */
module acf_classifier_props #(
    parameter PORT_W = 5,
    parameter NUM_PORTS = 28
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic frmValid,
    input wire logic [PORT_W-1:0] frmPort,
    input wire logic [15:0] frmLen,
    input wire logic resValid,
    input wire logic resHit,
    input wire logic resDrop,
    input wire logic resRateEn,
    input wire logic resSpolEn,
    input wire logic resRedirEn,
    input wire logic [PORT_W-1:0] resRedirPort,
    input wire logic resMirror,
    input wire logic resLog,
    input wire logic resShutdown,
    input wire logic [PORT_W-1:0] resShutPort
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    sequence frmTaken;
        frmValid && ce;
    endsequence
    sequence verdict;
        resValid;
    endsequence
    res_follows_a: assert property (frmTaken |=> resValid)
        else $error("no verdict after frame");
    res_pulse_a: assert property (ce && !frmValid |=> !resValid)
        else $error("verdict without frame");
    deny_quiet_a: assert property (verdict ##0 resDrop |->
        !resRateEn && !resSpolEn && !resRedirEn && !resMirror)
        else $error("deny acts");
    rate_pol_a: assert property (verdict |->
        !(resRateEn && resSpolEn)) else $error("limiter and policer both on");
    miss_quiet_a: assert property (verdict ##0 !resHit |-> !resDrop
        && !resMirror && !resLog && !resShutdown) else $error("miss acts");
    shut_port_a: assert property (verdict ##0 resShutdown
        |-> resShutPort == $past(frmPort)) else $error("wrong shut port");
    long_frame_a: assert property (frmTaken ##0
        frmLen >= 16'h05EE |=> !resLog && !resShutdown)
        else $error("long frame logged");
    redir_range_a: assert property (verdict ##0 resRedirEn
        |-> resRedirPort < NUM_PORTS) else $error("redirect out of range");
endmodule // acf_classifier_props

bind acf_classifier acf_classifier_props #(.PORT_W(PORT_W),
    .NUM_PORTS(NUM_PORTS)) acf_classifier_props_inst (.clk, .arst_n, .ce,
    .frmValid, .frmPort, .frmLen, .resValid, .resHit, .resDrop, .resRateEn,
    .resSpolEn, .resRedirEn, .resRedirPort, .resMirror, .resLog,
    .resShutdown, .resShutPort);

// file: bench/acf_fwd_sink.sv
/*
 * Forwarding pipeline model: keeps the last verdict it was handed.
 * Assumes the verdict is valid in the cycle resValid is high.
 */
module acf_fwd_sink (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic resValid,
    input wire logic [27:0] res,
    output logic [31:0] lastRes_q
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            lastRes_q <= 32'h0;
        else if (resValid)
            lastRes_q <= {4'h0, res};
    end
endmodule // acf_fwd_sink

// file: bench/tb_top.sv
/*
 * Testbench of the classifier: register access and frame verdicts.
 * Assumes a 100 MHz clock and the forwarding sink model beside it.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, arst_n = 1'b0;
    logic [11:0] awAddr = '0, arAddr = '0;
    logic [31:0] wData = '0, rData;
    logic [3:0] wStrb = '0;
    logic awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic awReady, wReady, bValid, arReady, rValid, resValid;
    logic [1:0] bResp, rResp;
    logic frmValid = 0;
    logic [4:0] frmPort = '0;
    logic [15:0] frmEtype = '0, frmLen = '0;
    logic [47:0] frmDa = '0;
    wire [27:0] res;
    logic [31:0] lastRes;
    logic [15:0] et [0:3] = '{16'h0806, 16'h0800, 16'h86DD, 16'h05FF};
    int mismatches = 0, nChecks = 0, c;
    always #5 clk = ~clk;
    acf_classifier acf_classifier_inst (.clk(clk), .arst_n(arst_n),
        .ce(1'b1), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .frmValid(frmValid), .frmPort(frmPort),
        .frmPolicy(8'h00), .frmEtype(frmEtype), .frmDa(frmDa),
        .frmSa(48'h0), .frmLen(frmLen), .resValid(resValid),
        .resHit(res[27]), .resEntry(res[26:24]), .resDrop(res[23]),
        .resRateEn(res[22]), .resRateId(res[21:18]), .resSpolEn(res[17]),
        .resSpolId(res[16:9]), .resRedirEn(res[8]),
        .resRedirPort(res[7:3]), .resMirror(res[2]), .resLog(res[1]),
        .resShutdown(res[0]), .resShutPort());
    acf_fwd_sink acf_fwd_sink_inst (.clk(clk), .arst_n(arst_n),
        .resValid(resValid), .res(res), .lastRes_q(lastRes));
    ////////////////////////////////////////////////////////////////////////
    task close_out;
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        nChecks++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] er);
        int i;
        @(posedge clk);
        awAddr <= a; wData <= d; wStrb <= 4'hF;
        awValid <= 1'b1; wValid <= 1'b1; bReady <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        bReady <= 1'b0;
        chk("bResp", 32'(bResp), 32'(er));
        if (i == 50) begin mismatches++; close_out(); end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int i;
        @(posedge clk);
        arAddr <= a; arValid <= 1'b1; rReady <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) break;
        end
        rReady <= 1'b0;
        chk("rResp", 32'(rResp), 32'(er));
        chk("rData", rData, e);
        if (i == 50) begin mismatches++; close_out(); end
    endtask
    task fr(input logic [15:0] t, input logic [47:0] da, input logic [15:0] n);
        @(posedge clk);
        frmValid <= 1'b1; frmPort <= 5'h06;
        frmEtype <= t; frmDa <= da; frmLen <= n;
        @(posedge clk);
        frmValid <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(12'h000, 32'h1, 2'h0);
        rd(12'hFFC, 32'h0, 2'h2);
        wr(12'hFFC, 32'h0, 2'h2);
        for (c = 2; c < 5; c++)
        begin
            wr(12'h100, 32'h1 | (c << 1), 2'h0);
            fr(et[c - 2], 48'h1, 16'h0040);
            chk("classHit", lastRes >> 23, 32'h10);
            fr(16'h0600, 48'h1, 16'h0040);
            chk("classMiss", lastRes >> 27, 32'h0);
        end
        wr(12'h100, 32'h13, 2'h0);
        for (c = 0; c < 4; c++)
        begin
            fr(et[c], 48'h1, 16'h0040);
            chk("etypeMiss", lastRes >> 27, 32'h0);
        end
        wr(12'h120, 32'h10DE1, 2'h0);
        wr(12'h124, 32'h1FFE0, 2'h0);
        fr(16'h0600, {48{1'b1}}, 16'h0040);
        chk("firstHit", lastRes, 32'h08800000);
        fr(16'h0800, {48{1'b1}}, 16'h0040);
        chk("permitAct", lastRes, 32'h0903FF1F);
        fr(16'h0800, 48'h1, 16'h0040);
        chk("ucMiss", lastRes >> 27, 32'h0);
        wr(12'h124, 32'h3F, 2'h0);
        fr(16'h0800, {48{1'b1}}, 16'h05EE);
        chk("longAct", lastRes, 32'h097C0004);
        rd(12'h11C, 32'h4, 2'h0);
        close_out();
    end
endmodule // tb_top
